// ==== verilog/lcdpx_pkg.sv ====
// Constants, types and register map of the LCD power gating and segment expansion block.
// Assumes an APB master on clk and a free running subclock on the link clock port.
//
// Behaviour
// - In watch, subactive and subsleep only a subclock frame source keeps the display alive.
// - The display runs only with display on set in active, sleep, watch, subactive or subsleep.
// - Standby turns the drive supply off whatever the drive supply switch says.
// - Standby gates the subclock to the LCD logic while the oscillator keeps running.
// - Module standby stops both the main clock and the subclock to the LCD logic.
// - Expansion select turns segment pins 32 to 29 into the four expansion signals.
// - Expansion shifts data out from the first RAM segment and pins 28 to 1 become ports.
// - Clearing display on stops with both clocks and polarity low and data held.
// - Standby floats every expansion pin.
// - The far driver must map data and polarity to drive levels its own way.
// - Static, 1/2, 1/3 and 1/4 duty are chosen by the two bit duty select.
package lcdpx_pkg;
	// ==========================================================================
	// Register map.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RAM_OFS = 8'h10;
	localparam int RAM_WORDS = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ==========================================================================
	// Field positions of the control register.
	localparam int DISPLAY_ON_BIT = 0;
	localparam int DRIVE_SUPPLY_BIT = 1;
	localparam int EXPANSION_BIT = 2;
	localparam int DRIVER_SEL_LSB = 4;
	localparam int DUTY_LSB = 8;
	localparam int FRAME_SEL_LSB = 12;
	// ==========================================================================
	// Frame clock codes and timing.
	localparam logic [3:0] FRAME_SUB_DIV1 = 4'h0;
	localparam logic [3:0] FRAME_SUB_DIV4 = 4'h2;
	localparam int MAIN_DIV_WIDTH = 16;
	localparam int BITS_PER_LINE = 32;
	typedef enum logic [2:0] {
		PM_ACTIVE, PM_SLEEP, PM_WATCH, PM_SUBACTIVE, PM_SUBSLEEP, PM_STANDBY
	} lcdpx_power_mode_type;
	typedef struct packed {
		logic [3:0] frameClockSelect;
		logic [1:0] dutySelect;
		logic [3:0] segmentDriverSelect;
		logic segmentExpansionSelect;
		logic driveSupplySwitch;
		logic displayOn;
	} lcdpx_ctrl_type;
	typedef struct packed {
		logic run;
		logic standby;
		logic [3:0] frameClockSelect;
		logic [1:0] dutySelect;
	} lcdpx_link_cfg_type;
	typedef struct packed {
		logic expansionClockOne;
		logic expansionClockTwo;
		logic polarity;
		logic serialData;
	} lcdpx_exp_pins_type;
endpackage

// ==== verilog/lcdpx_top.sv ====
// LCD power state gating, APB registers, segment RAM and expansion serializer.
// Assumes powerMode comes from logic on clk and subClk is the free running subclock.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_top #(
	parameter int DIV_WIDTH = lcdpx_pkg::MAIN_DIV_WIDTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic subClk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire lcdpx_pkg::lcdpx_power_mode_type powerMode,
	input wire logic moduleStandby,
	output logic displayRun,
	output logic driveSupplyOn,
	output logic mainClockEnable,
	output logic subClockEnable,
	output logic segPortMode,
	output lcdpx_pkg::lcdpx_exp_pins_type expPins,
	output logic [3:0] expPinsOe
);
	// ==========================================================================
	// Control register and segment RAM.
	lcdpx_pkg::lcdpx_ctrl_type ctrl_q;
	logic [31:0] ram_q [lcdpx_pkg::RAM_WORDS];
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic writeStrobe;
	logic ramHit;
	logic [1:0] ramIdx;
	logic subSource;
	logic subMode;
	logic clockMissing;
	logic linkActiveSync_q;
	logic linkActiveMeta_q;

	assign writeStrobe = psel && penable && pwrite;
	assign ramHit = (paddr >= lcdpx_pkg::RAM_OFS) && (paddr[1:0] == 2'h0)
		&& (paddr < 8'(lcdpx_pkg::RAM_OFS + 8'(4 * lcdpx_pkg::RAM_WORDS)));
	assign ramIdx = paddr[3:2];

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q.displayOn <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::DISPLAY_ON_BIT];
			ctrl_q.driveSupplySwitch <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::DRIVE_SUPPLY_BIT];
			ctrl_q.segmentExpansionSelect <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::EXPANSION_BIT];
			ctrl_q.segmentDriverSelect <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::DRIVER_SEL_LSB +: 4];
			ctrl_q.dutySelect <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::DUTY_LSB +: 2];
			ctrl_q.frameClockSelect <= lcdpx_pkg::CTRL_RESET[lcdpx_pkg::FRAME_SEL_LSB +: 4];
		end else if (writeStrobe && paddr == lcdpx_pkg::CTRL_OFS) begin
			ctrl_q.displayOn <= pwdata[lcdpx_pkg::DISPLAY_ON_BIT];
			ctrl_q.driveSupplySwitch <= pwdata[lcdpx_pkg::DRIVE_SUPPLY_BIT];
			ctrl_q.segmentExpansionSelect <= pwdata[lcdpx_pkg::EXPANSION_BIT];
			ctrl_q.segmentDriverSelect <= pwdata[lcdpx_pkg::DRIVER_SEL_LSB +: 4];
			ctrl_q.dutySelect <= pwdata[lcdpx_pkg::DUTY_LSB +: 2];
			ctrl_q.frameClockSelect <= pwdata[lcdpx_pkg::FRAME_SEL_LSB +: 4];
		end
	end

	always_ff @(posedge clk) begin
		if (writeStrobe && ramHit) begin
			ram_q[ramIdx] <= pwdata;
		end
	end

	// ==========================================================================
	// APB read data is prepared in the setup cycle and answered in the access cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			if (paddr == lcdpx_pkg::CTRL_OFS) begin
				prdata_q[lcdpx_pkg::DISPLAY_ON_BIT] <= ctrl_q.displayOn;
				prdata_q[lcdpx_pkg::DRIVE_SUPPLY_BIT] <= ctrl_q.driveSupplySwitch;
				prdata_q[lcdpx_pkg::EXPANSION_BIT] <= ctrl_q.segmentExpansionSelect;
				prdata_q[lcdpx_pkg::DRIVER_SEL_LSB +: 4] <= ctrl_q.segmentDriverSelect;
				prdata_q[lcdpx_pkg::DUTY_LSB +: 2] <= ctrl_q.dutySelect;
				prdata_q[lcdpx_pkg::FRAME_SEL_LSB +: 4] <= ctrl_q.frameClockSelect;
			end else if (paddr == lcdpx_pkg::STATUS_OFS) begin
				prdata_q[3:0] <= {clockMissing, linkActiveSync_q, driveSupplyOn, displayRun};
			end else if (ramHit) begin
				prdata_q <= ram_q[ramIdx];
			end else begin
				pslverr_q <= 1'b1;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = psel && penable;
	assign pslverr = psel && penable && pslverr_q;

	// ==========================================================================
	// Power state gating.
	assign subSource = ctrl_q.frameClockSelect <= lcdpx_pkg::FRAME_SUB_DIV4;
	assign subMode = powerMode inside {lcdpx_pkg::PM_WATCH, lcdpx_pkg::PM_SUBACTIVE,
		lcdpx_pkg::PM_SUBSLEEP};
	assign clockMissing = subMode && !subSource;
	assign displayRun = ctrl_q.displayOn && !moduleStandby && !clockMissing
		&& powerMode != lcdpx_pkg::PM_STANDBY;
	assign driveSupplyOn = ctrl_q.driveSupplySwitch && powerMode != lcdpx_pkg::PM_STANDBY;
	assign subClockEnable = !moduleStandby && powerMode != lcdpx_pkg::PM_STANDBY;
	assign mainClockEnable = !moduleStandby && !subMode
		&& powerMode != lcdpx_pkg::PM_STANDBY;
	assign segPortMode = ctrl_q.segmentExpansionSelect;

	// ==========================================================================
	// Main clock frame tick for non subclock sources, sent as a toggle.
	logic [DIV_WIDTH-1:0] divCnt_q;
	logic [DIV_WIDTH-1:0] divMask;
	logic mainTickTgl_q;

	assign divMask = (DIV_WIDTH'(1) << ctrl_q.frameClockSelect) - DIV_WIDTH'(1);

	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt_q <= '0;
			mainTickTgl_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_q + DIV_WIDTH'(1);
			if ((divCnt_q & divMask) == '0) begin
				mainTickTgl_q <= !mainTickTgl_q;
			end
		end
	end

	// ==========================================================================
	// Word fetch handshake, main side.
	logic [2:0] reqSync_q;
	logic ackTgl_q;
	logic [31:0] wordHold_q;
	logic [1:0] linkIdx_q;
	logic reqTgl_q;
	logic linkActive;

	always_ff @(posedge clk) begin
		if (rst) begin
			reqSync_q <= 3'h0;
			ackTgl_q <= 1'b0;
			wordHold_q <= 32'h0;
		end else begin
			reqSync_q <= {reqSync_q[1:0], reqTgl_q};
			if (reqSync_q[2] != reqSync_q[1]) begin
				wordHold_q <= ram_q[linkIdx_q];
				ackTgl_q <= !ackTgl_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			linkActiveMeta_q <= 1'b0;
			linkActiveSync_q <= 1'b0;
		end else begin
			linkActiveMeta_q <= linkActive;
			linkActiveSync_q <= linkActiveMeta_q;
		end
	end

	// ==========================================================================
	// Link domain: reset and configuration synchronisers.
	lcdpx_pkg::lcdpx_link_cfg_type cfgMain;
	lcdpx_pkg::lcdpx_link_cfg_type cfgMeta_q;
	lcdpx_pkg::lcdpx_link_cfg_type cfg_q;
	logic [1:0] linkRst_q;
	logic linkRst;
	logic [2:0] ackSync_q;
	logic [2:0] tickSync_q;

	assign cfgMain = '{run: displayRun && ctrl_q.segmentExpansionSelect,
		standby: powerMode == lcdpx_pkg::PM_STANDBY || moduleStandby,
		frameClockSelect: ctrl_q.frameClockSelect, dutySelect: ctrl_q.dutySelect};
	assign linkRst = linkRst_q[1];

	always_ff @(posedge subClk) begin
		linkRst_q <= {linkRst_q[0], rst};
		cfgMeta_q <= cfgMain;
		cfg_q <= cfgMeta_q;
		ackSync_q <= {ackSync_q[1:0], ackTgl_q};
		tickSync_q <= {tickSync_q[1:0], mainTickTgl_q};
	end

	// ==========================================================================
	// Link domain: step tick from the selected frame clock.
	logic [1:0] subDiv_q;
	logic stepTick;

	always_ff @(posedge subClk) begin
		if (linkRst) begin
			subDiv_q <= 2'h0;
		end else begin
			subDiv_q <= subDiv_q + 2'h1;
		end
	end

	always_comb begin
		unique case (cfg_q.frameClockSelect)
			4'h0: stepTick = 1'b1;
			4'h1: stepTick = subDiv_q[0];
			4'h2: stepTick = subDiv_q == 2'h3;
			default: stepTick = tickSync_q[2] != tickSync_q[1];
		endcase
	end

	// ==========================================================================
	// Link domain: expansion serializer.
	typedef enum logic [1:0] {LK_IDLE, LK_FETCH, LK_SHIFT, LK_LATCH} lcdpx_link_state_type;
	lcdpx_link_state_type state_q;
	lcdpx_pkg::lcdpx_exp_pins_type pins_q;
	logic [31:0] shift_q;
	logic [4:0] bitCnt_q;
	logic [1:0] common_q;
	logic [3:0] oe_q;

	assign linkActive = state_q != LK_IDLE;
	assign linkIdx_q = common_q;

	always_ff @(posedge subClk) begin
		if (linkRst || !cfg_q.run) begin
			state_q <= LK_IDLE;
			common_q <= 2'h0;
			pins_q.expansionClockOne <= 1'b0;
			pins_q.expansionClockTwo <= 1'b0;
			pins_q.polarity <= 1'b0;
			reqTgl_q <= linkRst ? 1'b0 : reqTgl_q;
			pins_q.serialData <= linkRst ? 1'b0 : pins_q.serialData;
			shift_q <= linkRst ? 32'h0 : shift_q;
			bitCnt_q <= 5'h0;
		end else begin
			unique case (state_q)
				LK_IDLE: begin
					reqTgl_q <= !reqTgl_q;
					state_q <= LK_FETCH;
				end
				LK_FETCH: begin
					if (ackSync_q[2] != ackSync_q[1]) begin
						shift_q <= wordHold_q;
						bitCnt_q <= 5'h0;
						state_q <= LK_SHIFT;
					end
				end
				LK_SHIFT: begin
					if (stepTick && !pins_q.expansionClockTwo) begin
						pins_q.serialData <= shift_q[0];
						pins_q.expansionClockTwo <= 1'b1;
					end else if (stepTick) begin
						pins_q.expansionClockTwo <= 1'b0;
						shift_q <= {1'b0, shift_q[31:1]};
						bitCnt_q <= bitCnt_q + 5'h1;
						if (bitCnt_q == 5'(lcdpx_pkg::BITS_PER_LINE - 1)) begin
							state_q <= LK_LATCH;
						end
					end
				end
				LK_LATCH: begin
					if (stepTick && !pins_q.expansionClockOne) begin
						pins_q.expansionClockOne <= 1'b1;
					end else if (stepTick) begin
						pins_q.expansionClockOne <= 1'b0;
						if (common_q >= cfg_q.dutySelect) begin
							common_q <= 2'h0;
							pins_q.polarity <= !pins_q.polarity;
						end else begin
							common_q <= common_q + 2'h1;
						end
						reqTgl_q <= !reqTgl_q;
						state_q <= LK_FETCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge subClk) begin
		if (linkRst || cfg_q.standby) begin
			oe_q <= 4'h0;
		end else begin
			oe_q <= 4'hf;
		end
	end

	assign expPins = pins_q;
	assign expPinsOe = oe_q;

	// ==========================================================================
	// Checks.
	a_standby_stops_display: assert property (@(posedge clk) disable iff (rst)
		powerMode == lcdpx_pkg::PM_STANDBY |-> !displayRun && !driveSupplyOn)
		else $error("Display or supply on during standby.");
	a_off_bit_stops: assert property (@(posedge clk) disable iff (rst)
		!ctrl_q.displayOn |-> !displayRun)
		else $error("Display runs with display on cleared.");
	a_supply_follows_switch: assert property (@(posedge clk) disable iff (rst)
		$rose(ctrl_q.driveSupplySwitch) && powerMode != lcdpx_pkg::PM_STANDBY
		|-> driveSupplyOn)
		else $error("Drive supply ignores its switch outside standby.");
	a_sub_clock_gate: assert property (@(posedge clk) disable iff (rst)
		powerMode == lcdpx_pkg::PM_STANDBY |-> !subClockEnable)
		else $error("Subclock delivered during standby.");
	a_module_standby_gate: assert property (@(posedge clk) disable iff (rst)
		moduleStandby |-> !subClockEnable && !mainClockEnable)
		else $error("Clock delivered in module standby.");
	a_missing_clock_halts: assert property (@(posedge clk) disable iff (rst)
		subMode && ctrl_q.frameClockSelect > lcdpx_pkg::FRAME_SUB_DIV4 |-> !displayRun)
		else $error("Display runs without a subclock source.");
	a_port_mode_follows: assert property (@(posedge clk) disable iff (rst)
		writeStrobe && paddr == lcdpx_pkg::CTRL_OFS
		|=> segPortMode == $past(pwdata[lcdpx_pkg::EXPANSION_BIT]))
		else $error("Segment pin mode does not follow expansion select.");
	a_stop_levels: assert property (@(posedge subClk) disable iff (linkRst)
		!cfg_q.run |=> !pins_q.expansionClockOne && !pins_q.expansionClockTwo
		&& !pins_q.polarity && pins_q.serialData == $past(pins_q.serialData))
		else $error("Expansion pins not parked after stop.");
	a_standby_float: assert property (@(posedge subClk) disable iff (linkRst)
		cfg_q.standby |=> oe_q == 4'h0)
		else $error("Expansion pins driven in standby.");
	a_resume_first_common: assert property (@(posedge subClk) disable iff (linkRst)
		$rose(linkActive) |-> common_q == 2'h0 ##1 state_q == LK_FETCH)
		else $error("Resume does not start at the first common.");
	a_common_in_duty: assert property (@(posedge subClk) disable iff (linkRst)
		state_q == LK_SHIFT |-> common_q <= cfg_q.dutySelect)
		else $error("Common phase beyond duty.");
endmodule // lcdpx_top
`default_nettype wire

// ==== dv/lcdpx_seg_driver_model.sv ====
// Behavioural far side segment driver fed by the four expansion pins.
// Assumes the pins carry meaning only while every output enable is high.
`timescale 1ns/1ps
`default_nettype none
module lcdpx_seg_driver_model (
	input wire lcdpx_pkg::lcdpx_exp_pins_type expPins,
	input wire logic [3:0] expPinsOe,
	output logic [31:0] lastLine,
	output int lineCount
);
	// ==========================================================================
	// Shift register and line latch.
	logic [31:0] shiftQ;
	initial begin
		shiftQ = 32'h0;
		lastLine = 32'h0;
		lineCount = 0;
	end
	// Data and polarity are kept raw, so level mapping stays with this driver.
	always @(negedge expPins.expansionClockTwo) begin
		if (expPinsOe == 4'hf)
			shiftQ <= {expPins.serialData, shiftQ[31:1]};
	end
	always @(posedge expPins.expansionClockOne) begin
		if (expPinsOe == 4'hf) begin
			lastLine <= shiftQ;
			lineCount <= lineCount + 1;
		end
	end
endmodule // lcdpx_seg_driver_model
`default_nettype wire

// ==== dv/lcdpx_top_tb.sv ====
// Self-checking bench for the LCD power gating and expansion block.
// Assumes the far side driver model and an APB master built from tasks here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checkCount++; if ((gt) !== (ex)) begin nFail++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module lcdpx_top_tb;
	typedef struct {
		lcdpx_pkg::lcdpx_power_mode_type mode;
		logic [15:0] ctrl;
		logic ms;
		logic [3:0] exp;
		logic [3:0] care;
	} lcdpx_row_type;
	// ==========================================================================
	// Signals and rows: expected bits are run, supply, main clock, subclock.
	logic clk = 1'b0;
	logic subClk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic moduleStandby = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	lcdpx_pkg::lcdpx_power_mode_type powerMode = lcdpx_pkg::PM_ACTIVE;
	logic [31:0] prdata, rdData, lastLine, ctrl;
	logic pready, pslverr, displayRun, driveSupplyOn, mainClockEnable, subClockEnable;
	logic segPortMode, rdErr, heldData;
	lcdpx_pkg::lcdpx_exp_pins_type expPins;
	logic [3:0] expPinsOe, seen;
	int lineCount, n0;
	int nFail = 0;
	int checkCount = 0;
	lcdpx_row_type rows [9] = '{
		'{lcdpx_pkg::PM_ACTIVE, 16'h0003, 1'b0, 4'hf, 4'hf},
		'{lcdpx_pkg::PM_ACTIVE, 16'h0002, 1'b0, 4'h4, 4'hc},
		'{lcdpx_pkg::PM_SLEEP, 16'h0001, 1'b0, 4'h8, 4'h8},
		'{lcdpx_pkg::PM_WATCH, 16'h0001, 1'b0, 4'h9, 4'hf},
		'{lcdpx_pkg::PM_SUBACTIVE, 16'h2001, 1'b0, 4'h8, 4'h8},
		'{lcdpx_pkg::PM_SUBSLEEP, 16'h3001, 1'b0, 4'h0, 4'h8},
		'{lcdpx_pkg::PM_WATCH, 16'h1001, 1'b0, 4'h8, 4'h8},
		'{lcdpx_pkg::PM_STANDBY, 16'h0003, 1'b0, 4'h0, 4'hd},
		'{lcdpx_pkg::PM_ACTIVE, 16'h0003, 1'b1, 4'h0, 4'hb}
	};
	lcdpx_top lcdpx_top_i (.clk(clk), .rst(rst), .subClk(subClk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .powerMode(powerMode),
		.moduleStandby(moduleStandby), .displayRun(displayRun),
		.driveSupplyOn(driveSupplyOn), .mainClockEnable(mainClockEnable),
		.subClockEnable(subClockEnable), .segPortMode(segPortMode),
		.expPins(expPins), .expPinsOe(expPinsOe));
	lcdpx_seg_driver_model lcdpx_seg_driver_model_i (.expPins(expPins),
		.expPinsOe(expPinsOe), .lastLine(lastLine), .lineCount(lineCount));
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#3.7;
		forever #7.5 subClk = ~subClk;
	end
	// ==========================================================================
	// Tasks.
	function automatic logic [31:0] ramWord(input int i);
		return 32'hc3a5_0f01 + 32'h1021_0e07 * 32'(i);
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitLine(input int target);
		while (lineCount < target) begin
			@(posedge clk);
		end
	endtask
	task automatic subWait(input int n);
		repeat (n) @(posedge subClk);
		@(posedge clk);
	endtask
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		nFail++;
		$display("watchdog expired");
		reportAndStop();
	end
	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		`CHK("runInReset", 1'b0, displayRun)
		apb(1'b0, lcdpx_pkg::CTRL_OFS, 32'h0);
		`CHK("ctrlReset", lcdpx_pkg::CTRL_RESET, rdData)
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmappedErr", 1'b1, rdErr)
		$display("test reset done");
		foreach (rows[i]) begin
			powerMode <= rows[i].mode;
			moduleStandby <= rows[i].ms;
			apb(1'b1, lcdpx_pkg::CTRL_OFS, {16'h0, rows[i].ctrl});
			repeat (2) @(posedge clk);
			seen = {displayRun, driveSupplyOn, mainClockEnable, subClockEnable};
			`CHK($sformatf("row%0d", i), rows[i].exp & rows[i].care, seen & rows[i].care)
		end
		moduleStandby <= 1'b0;
		powerMode <= lcdpx_pkg::PM_ACTIVE;
		$display("test power rows done");
		for (int i = 0; i < 4; i++)
			apb(1'b1, lcdpx_pkg::RAM_OFS + 8'(4 * i), ramWord(i));
		for (int d = 0; d < 4; d++) begin
			ctrl = (32'(d & 1) << lcdpx_pkg::DRIVER_SEL_LSB) | (32'(d) << lcdpx_pkg::DUTY_LSB);
			ctrl = ctrl | (32'h1 << lcdpx_pkg::EXPANSION_BIT);
			apb(1'b1, lcdpx_pkg::CTRL_OFS, ctrl);
			subWait(8);
			n0 = lineCount;
			apb(1'b1, lcdpx_pkg::CTRL_OFS, ctrl | 32'h1);
			for (int k = 1; k <= d + 2; k++) begin
				waitLine(n0 + k);
				`CHK("lineWord", ramWord((k - 1) % (d + 1)), lastLine)
			end
		end
		`CHK("portMode", 1'b1, segPortMode)
		`CHK("oeOn", 4'hf, expPinsOe)
		apb(1'b0, lcdpx_pkg::STATUS_OFS, 32'h0);
		`CHK("status", 4'h5, rdData[3:0])
		apb(1'b0, lcdpx_pkg::RAM_OFS + 8'h08, 32'h0);
		`CHK("ramRead", ramWord(2), rdData)
		$display("test expansion done");
		apb(1'b1, lcdpx_pkg::CTRL_OFS, ctrl);
		subWait(8);
		`CHK("haltPins", 3'b000, {expPins.expansionClockOne, expPins.expansionClockTwo, expPins.polarity})
		heldData = expPins.serialData;
		subWait(20);
		`CHK("haltData", heldData, expPins.serialData)
		$display("test halt done");
		apb(1'b1, lcdpx_pkg::CTRL_OFS, ctrl | 32'h1);
		subWait(40);
		powerMode <= lcdpx_pkg::PM_STANDBY;
		subWait(8);
		`CHK("oeStandby", 4'h0, expPinsOe)
		powerMode <= lcdpx_pkg::PM_ACTIVE;
		subWait(8);
		`CHK("oeBack", 4'hf, expPinsOe)
		$display("test standby done");
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("runMidReset", 1'b0, displayRun)
		`CHK("oeMidReset", 4'h0, expPinsOe)
		rst <= 1'b0;
		apb(1'b0, lcdpx_pkg::CTRL_OFS, 32'h0);
		`CHK("ctrlAfterReset", lcdpx_pkg::CTRL_RESET, rdData)
		$display("test mid reset done");
		reportAndStop();
	end
endmodule // lcdpx_top_tb
`default_nettype wire
